// ### include/gmlc_pkg.sv
// Purpose: shared constants for the modem serial link controller
// Assumes: 50 MHz reference clock, AHB-Lite register access
// Notes:   byte offsets, field positions, reset values and timing counts
package gmlc_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] GMLC_A_CFG      = 8'h00;
  localparam logic [7:0] GMLC_A_CTRL     = 8'h04;
  localparam logic [7:0] GMLC_A_DELAY    = 8'h08;
  localparam logic [7:0] GMLC_A_PIN      = 8'h0c;
  localparam logic [7:0] GMLC_A_MSC      = 8'h10;
  localparam logic [7:0] GMLC_A_GSC      = 8'h14;
  localparam logic [7:0] GMLC_A_DST0     = 8'h18;
  localparam logic [7:0] GMLC_A_DST1     = 8'h1c;
  localparam logic [7:0] GMLC_A_DST2     = 8'h20;
  localparam logic [7:0] GMLC_A_VALID    = 8'h24;
  localparam logic [7:0] GMLC_A_STATUS   = 8'h28;
  localparam logic [7:0] GMLC_A_IRQ_ST   = 8'h2c;
  localparam logic [7:0] GMLC_A_IRQ_MSK  = 8'h30;
  localparam logic [7:0] GMLC_A_CMD_CHR  = 8'h34;
  localparam logic [7:0] GMLC_A_TXDATA   = 8'h38;
  localparam logic [7:0] GMLC_A_RXDATA   = 8'h3c;
  localparam logic [7:0] GMLC_A_REPORT   = 8'h40;
  localparam logic [7:0] GMLC_A_LINK     = 8'h44;
  // ----------------------------------------------------------------
  // field positions and values
  // ----------------------------------------------------------------
  localparam int         GMLC_CFG_D8     = 0;
  localparam int         GMLC_CFG_PAR_LO = 1;
  localparam int         GMLC_CFG_STOP2  = 3;
  localparam int         GMLC_CFG_FAST   = 4;
  localparam int         GMLC_CFG_PERMIT = 5;
  localparam logic [4:0] GMLC_CFG_FMT_RST = 5'h01;
  localparam logic [1:0] GMLC_PAR_NONE   = 2'h0;
  localparam logic [1:0] GMLC_PAR_ODD    = 2'h1;
  localparam logic [1:0] GMLC_PAR_EVEN   = 2'h2;
  localparam int         GMLC_CTL_DEFLT  = 0;
  localparam int         GMLC_CTL_INIT   = 1;
  localparam int         GMLC_CTL_PINCAN = 2;
  localparam int         GMLC_CTL_CMDCLR = 3;
  localparam int         GMLC_DST_GW     = 31;
  localparam int         GMLC_TX_SMS     = 8;
  localparam logic [15:0] GMLC_RPT_MASK  = 16'hf078;
  localparam logic [5:0] GMLC_IRQ_RST    = 6'h00;
  localparam int         GMLC_IRQ_INITOK = 0;
  localparam int         GMLC_IRQ_CONERR = 1;
  localparam int         GMLC_IRQ_PINERR = 2;
  localparam int         GMLC_IRQ_RXBYTE = 3;
  localparam int         GMLC_IRQ_RXERR  = 4;
  localparam int         GMLC_IRQ_REFUSE = 5;
  localparam logic [3:0] GMLC_DELAY_MAX  = 4'ha;
  localparam logic [3:0] GMLC_DIGIT_MAX  = 4'h9;
  localparam int         GMLC_CMD_DEPTH  = 16;
  localparam logic [7:0] GMLC_CHR_CR     = 8'h0d;
  localparam logic [7:0] GMLC_CHR_O      = 8'h4f;
  localparam logic [7:0] GMLC_CHR_K      = 8'h4b;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int GMLC_CLK_HZ     = 50_000_000;
  localparam int GMLC_BAUD_LO    = 9600;
  localparam int GMLC_BAUD_HI    = 19200;
  localparam int GMLC_RSP_MS     = 1000;
  localparam int GMLC_BITC_LO    = GMLC_CLK_HZ / GMLC_BAUD_LO;
  localparam logic [12:0] GMLC_BITC_HI = 13'(GMLC_CLK_HZ / GMLC_BAUD_HI);
  localparam int GMLC_CYC_SEC    = GMLC_CLK_HZ;
  localparam int GMLC_RSP_CYC    = (GMLC_CLK_HZ / 1000) * GMLC_RSP_MS;
  // ----------------------------------------------------------------
  // init sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    GMLC_S_IDLE  = 3'b000,
    GMLC_S_DELAY = 3'b001,
    GMLC_S_SEND  = 3'b010,
    GMLC_S_WAIT  = 3'b011,
    GMLC_S_DONE  = 3'b100
  } gmlc_state_t;
endpackage : gmlc_pkg

// ### hw/gmlc_top.sv
// Purpose: serial link controller between a controller and a GSM modem
// Assumes: AHB-Lite slave, single clock, synchronous active-high reset
// Notes:   one init command buffer, one uart, status word and interrupts
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module gmlc_top
  import gmlc_pkg::*;
#(
  parameter logic [12:0] P_BIT_CYC_LO  = 13'(GMLC_BITC_LO),
  parameter logic [25:0] P_CYC_PER_SEC = 26'(GMLC_CYC_SEC),
  parameter logic [25:0] P_RSP_CYC     = 26'(GMLC_RSP_CYC)
) (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  // modem serial pins
  output logic             o_txd,
  input  wire logic        i_rxd,
  // interrupt
  output logic             o_irq
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic par_bit(input logic [7:0] d, input logic d8,
                                   input logic [1:0] par);
    logic p;
    p = d8 ? ^d : ^d[6:0];
    return (par == GMLC_PAR_ODD) ? ~p : p;
  endfunction : par_bit

  // frame length without the second stop bit
  function automatic logic [3:0] base_len(input logic d8, input logic [1:0] par);
    logic [3:0] n;
    n = d8 ? 4'ha : 4'h9;
    if (par != GMLC_PAR_NONE) n = n + 4'h1;
    return n;
  endfunction : base_len

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [5:0]  cfg_q;
  logic [3:0]  delay_q;
  logic [15:0] pin_q;
  logic        pin_set_q;
  logic [31:0] msc_q;
  logic [31:0] gsc_q;
  logic [31:0] dst_q [3];
  logic [7:0]  valid_q;
  logic [15:0] report_q;
  logic        conn_err_q;
  logic        init_ok_q;
  logic [5:0]  irq_st_q;
  logic [5:0]  irq_msk_q;
  logic [5:0]  ev;
  logic [7:0]  cmd_q [GMLC_CMD_DEPTH];
  logic [4:0]  cmd_len_q;
  logic [7:0]  rx_data_q;
  logic        rd_pend_q;
  logic        wr_pend_q;
  logic [7:0]  addr_q;
  logic        hready_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  logic [15:0] status;
  logic        we;
  logic [31:0] wd;
  logic        addr_ok;
  logic        d8;
  logic [1:0]  par;
  logic [12:0] bit_cyc;
  gmlc_state_t st_q;
  logic [4:0]  idx_q;
  logic [3:0]  sec_left_q;
  logic [25:0] tmr_q;
  logic        saw_o_q;
  logic        seq_req;
  logic        sw_req;
  logic        tx_start;
  logic [7:0]  tx_byte;
  logic        tx_busy_q;
  logic [11:0] tx_sh_q;
  logic [3:0]  tx_left_q;
  logic [12:0] tx_cnt_q;
  logic        txd_q;
  logic [11:0] frame;
  logic [3:0]  frame_n;
  logic        rx_s1_q;
  logic        rx_s2_q;
  logic        rx_busy_q;
  logic [12:0] rx_cnt_q;
  logic [3:0]  rx_left_q;
  logic [11:0] rx_sh_q;
  logic        rx_done_q;
  logic [11:0] rx_f;
  logic [7:0]  rx_d;
  logic        rx_ok;
  logic        gw_clash;
  logic        pin_digits_ok;
  logic        irq_q;

  assign d8      = cfg_q[GMLC_CFG_D8];
  assign par     = cfg_q[GMLC_CFG_PAR_LO +: 2];
  assign bit_cyc = cfg_q[GMLC_CFG_FAST] ? GMLC_BITC_HI : P_BIT_CYC_LO;

  // ----------------------------------------------------------------
  // ahb-lite slave: zero-wait writes, one wait state on reads
  // ----------------------------------------------------------------
  assign addr_ok = i_hsel & i_hready & i_htrans[1];
  assign we      = wr_pend_q;
  assign wd      = i_hwdata;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
      hready_q  <= 1'b1;
      hrdata_q  <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_ok & i_hwrite;
      rd_pend_q <= addr_ok & ~i_hwrite;
      if (addr_ok) addr_q <= i_haddr;
      // read data is built a cycle late so a write just before is seen
      hready_q  <= ~(addr_ok & ~i_hwrite);
      hrdata_q  <= rd_pend_q ? rd_mux : 32'h0000_0000;
    end
  end

  assign status = {report_q[15:12], 5'h00, report_q[6:3],
                   pin_set_q, init_ok_q, conn_err_q};

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr_q)
      GMLC_A_CFG:     rd_mux = {26'h0, cfg_q};
      GMLC_A_DELAY:   rd_mux = {28'h0, delay_q};
      GMLC_A_PIN:     rd_mux = {16'h0, pin_q};
      GMLC_A_MSC:     rd_mux = msc_q;
      GMLC_A_GSC:     rd_mux = gsc_q;
      GMLC_A_DST0:    rd_mux = dst_q[0];
      GMLC_A_DST1:    rd_mux = dst_q[1];
      GMLC_A_DST2:    rd_mux = dst_q[2];
      GMLC_A_VALID:   rd_mux = {24'h0, valid_q};
      GMLC_A_STATUS:  rd_mux = {16'h0, status};
      GMLC_A_IRQ_ST:  rd_mux = {26'h0, irq_st_q};
      GMLC_A_IRQ_MSK: rd_mux = {26'h0, irq_msk_q};
      GMLC_A_RXDATA:  rd_mux = {24'h0, rx_data_q};
      GMLC_A_REPORT:  rd_mux = {16'h0, report_q};
      GMLC_A_LINK:    rd_mux = {23'h0, cmd_len_q, st_q, tx_busy_q};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // configuration and stored numbers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cfg_q   <= {1'b0, GMLC_CFG_FMT_RST};
      delay_q <= 4'h0;
      valid_q <= 8'h00;
      msc_q   <= 32'h0000_0000;
      gsc_q   <= 32'h0000_0000;
    end else if (we) begin
      if (addr_q == GMLC_A_CFG && wd[GMLC_CFG_PAR_LO +: 2] != 2'h3)
        cfg_q <= wd[5:0];
      if (addr_q == GMLC_A_CTRL && wd[GMLC_CTL_DEFLT])
        cfg_q[4:0] <= GMLC_CFG_FMT_RST;
      if (addr_q == GMLC_A_DELAY)
        delay_q <= (wd[3:0] > GMLC_DELAY_MAX) ? GMLC_DELAY_MAX : wd[3:0];
      // full 8-bit code spans 5 min to 63 weeks, so no clamp needed
      if (addr_q == GMLC_A_VALID) valid_q <= wd[7:0];
      if (addr_q == GMLC_A_MSC)   msc_q   <= wd;
      if (addr_q == GMLC_A_GSC)   gsc_q   <= wd;
    end
  end

  // a second gateway slot would break the three-destination layout
  always_comb begin
    gw_clash = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (addr_q != GMLC_A_DST0 + 8'(4 * i) && dst_q[i][GMLC_DST_GW])
        gw_clash = wd[GMLC_DST_GW];
    end
  end

  generate
    for (genvar g = 0; g < 3; g++) begin : g_dst
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          dst_q[g] <= 32'h0000_0000;
        end else if (we && addr_q == GMLC_A_DST0 + 8'(4 * g) && !gw_clash) begin
          dst_q[g] <= wd;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // pin code
  // ----------------------------------------------------------------
  always_comb begin
    pin_digits_ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (wd[4*i +: 4] > GMLC_DIGIT_MAX) pin_digits_ok = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pin_q     <= 16'h0000;
      pin_set_q <= 1'b0;
    end else if (we && addr_q == GMLC_A_PIN && pin_digits_ok) begin
      pin_q     <= wd[15:0];
      pin_set_q <= 1'b1;
    end else if (we && addr_q == GMLC_A_CTRL && wd[GMLC_CTL_PINCAN]) begin
      pin_q     <= 16'h0000;
      pin_set_q <= 1'b0;
    end
  end

  // modem-reported flags kept by firmware; status itself takes no writes
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) report_q <= 16'h0000;
    else if (we && addr_q == GMLC_A_REPORT) report_q <= wd[15:0] & GMLC_RPT_MASK;
  end

  // ----------------------------------------------------------------
  // init command buffer
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cmd_len_q <= 5'h00;
    end else if (we && addr_q == GMLC_A_CTRL && wd[GMLC_CTL_CMDCLR]) begin
      cmd_len_q <= 5'h00;
    end else if (we && addr_q == GMLC_A_CMD_CHR && cmd_len_q < 5'(GMLC_CMD_DEPTH)) begin
      cmd_len_q <= cmd_len_q + 5'h01;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (we && addr_q == GMLC_A_CMD_CHR && cmd_len_q < 5'(GMLC_CMD_DEPTH))
      cmd_q[cmd_len_q[3:0]] <= wd[7:0];
  end

  // ----------------------------------------------------------------
  // init sequencer: delay, send command plus cr, wait for ok
  // ----------------------------------------------------------------
  assign seq_req = (st_q == GMLC_S_SEND) & ~tx_busy_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_q       <= GMLC_S_IDLE;
      idx_q      <= 5'h00;
      sec_left_q <= 4'h0;
      tmr_q      <= 26'h0;
      saw_o_q    <= 1'b0;
      init_ok_q  <= 1'b0;
      conn_err_q <= 1'b0;
    end else if (we && addr_q == GMLC_A_CTRL && wd[GMLC_CTL_INIT]) begin
      st_q       <= GMLC_S_DELAY;
      sec_left_q <= delay_q;
      tmr_q      <= P_CYC_PER_SEC - 26'h1;
      init_ok_q  <= 1'b0;
      conn_err_q <= 1'b0;
    end else begin
      unique case (st_q)
        GMLC_S_IDLE, GMLC_S_DONE: ;
        GMLC_S_DELAY: begin
          if (sec_left_q == 4'h0) begin
            st_q  <= GMLC_S_SEND;
            idx_q <= 5'h00;
          end else if (tmr_q == 26'h0) begin
            sec_left_q <= sec_left_q - 4'h1;
            tmr_q      <= P_CYC_PER_SEC - 26'h1;
          end else begin
            tmr_q <= tmr_q - 26'h1;
          end
        end
        GMLC_S_SEND: begin
          if (seq_req) begin
            idx_q <= idx_q + 5'h01;
            if (idx_q == cmd_len_q) begin
              st_q    <= GMLC_S_WAIT;
              tmr_q   <= P_RSP_CYC;
              saw_o_q <= 1'b0;
            end
          end
        end
        GMLC_S_WAIT: begin
          if (rx_done_q && rx_ok && saw_o_q && rx_d == GMLC_CHR_K) begin
            st_q      <= GMLC_S_DONE;
            init_ok_q <= 1'b1;
          end else if (tmr_q == 26'h0) begin
            st_q       <= GMLC_S_IDLE;
            conn_err_q <= 1'b1;
          end else begin
            tmr_q <= tmr_q - 26'h1;
            if (rx_done_q) saw_o_q <= rx_ok && rx_d == GMLC_CHR_O;
          end
        end
        default: st_q <= GMLC_S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  // message bytes are refused while remote access is permitted
  assign sw_req = we && addr_q == GMLC_A_TXDATA && !tx_busy_q && !seq_req &&
                  !(wd[GMLC_TX_SMS] && cfg_q[GMLC_CFG_PERMIT]);
  assign tx_start = seq_req | sw_req;
  assign tx_byte  = !seq_req ? wd[7:0] :
                    (idx_q == cmd_len_q) ? GMLC_CHR_CR : cmd_q[idx_q[3:0]];

  always_comb begin
    frame          = 12'hfff;
    frame[0]       = 1'b0;
    frame_n        = base_len(d8, par);
    if (d8) frame[8:1] = tx_byte;
    else    frame[7:1] = tx_byte[6:0];
    if (par != GMLC_PAR_NONE)
      frame[frame_n - 4'h2] = par_bit(tx_byte, d8, par);
    if (cfg_q[GMLC_CFG_STOP2]) frame_n = frame_n + 4'h1;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      tx_busy_q <= 1'b0;
      tx_sh_q   <= 12'hfff;
      tx_left_q <= 4'h0;
      tx_cnt_q  <= 13'h0;
      txd_q     <= 1'b1;
    end else if (tx_start) begin
      tx_busy_q <= 1'b1;
      txd_q     <= frame[0];
      tx_sh_q   <= {1'b1, frame[11:1]};
      tx_left_q <= frame_n - 4'h1;
      tx_cnt_q  <= bit_cyc - 13'h1;
    end else if (tx_busy_q) begin
      if (tx_cnt_q != 13'h0) begin
        tx_cnt_q <= tx_cnt_q - 13'h1;
      end else if (tx_left_q != 4'h0) begin
        txd_q     <= tx_sh_q[0];
        tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
        tx_left_q <= tx_left_q - 4'h1;
        tx_cnt_q  <= bit_cyc - 13'h1;
      end else begin
        tx_busy_q <= 1'b0;
        txd_q     <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver: mid-bit sampling, checks one stop bit only
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= i_rxd;
      rx_s2_q <= rx_s1_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q  <= 13'h0;
      rx_left_q <= 4'h0;
      rx_sh_q   <= 12'h000;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rx_s2_q) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q  <= {1'b0, bit_cyc[12:1]};
          rx_left_q <= base_len(d8, par);
        end
      end else if (rx_cnt_q != 13'h0) begin
        rx_cnt_q <= rx_cnt_q - 13'h1;
      end else begin
        rx_sh_q   <= {rx_s2_q, rx_sh_q[11:1]};
        rx_left_q <= rx_left_q - 4'h1;
        rx_cnt_q  <= bit_cyc - 13'h1;
        if (rx_left_q == 4'h1) begin
          rx_busy_q <= 1'b0;
          rx_done_q <= 1'b1;
        end
      end
    end
  end

  assign rx_f  = rx_sh_q >> (4'hc - base_len(d8, par));
  assign rx_d  = d8 ? rx_f[8:1] : {1'b0, rx_f[7:1]};
  assign rx_ok = !rx_f[0] && rx_f[base_len(d8, par) - 4'h1] &&
                 (par == GMLC_PAR_NONE ||
                  rx_f[base_len(d8, par) - 4'h2] == par_bit(rx_d, d8, par));

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) rx_data_q <= 8'h00;
    else if (rx_done_q && rx_ok) rx_data_q <= rx_d;
  end

  // ----------------------------------------------------------------
  // interrupts: sticky, write one to clear, a new event wins
  // ----------------------------------------------------------------
  always_comb begin
    ev                  = 6'h00;
    ev[GMLC_IRQ_INITOK] = rx_done_q && rx_ok && saw_o_q && rx_d == GMLC_CHR_K &&
                          st_q == GMLC_S_WAIT;
    ev[GMLC_IRQ_CONERR] = st_q == GMLC_S_WAIT && tmr_q == 26'h0 &&
                          !(rx_done_q && rx_ok && saw_o_q && rx_d == GMLC_CHR_K);
    ev[GMLC_IRQ_PINERR] = we && addr_q == GMLC_A_PIN && !pin_digits_ok;
    ev[GMLC_IRQ_RXBYTE] = rx_done_q && rx_ok;
    ev[GMLC_IRQ_RXERR]  = rx_done_q && !rx_ok;
    ev[GMLC_IRQ_REFUSE] = we && addr_q == GMLC_A_TXDATA && !sw_req;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      irq_st_q  <= GMLC_IRQ_RST;
      irq_msk_q <= GMLC_IRQ_RST;
      irq_q     <= 1'b0;
    end else begin
      if (we && addr_q == GMLC_A_IRQ_ST) irq_st_q <= (irq_st_q & ~wd[5:0]) | ev;
      else                               irq_st_q <= irq_st_q | ev;
      if (we && addr_q == GMLC_A_IRQ_MSK) irq_msk_q <= wd[5:0];
      irq_q <= |(irq_st_q & irq_msk_q);
    end
  end

  assign o_hreadyout = hready_q;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = hrdata_q;
  assign o_txd       = txd_q;
  assign o_irq       = irq_q;
endmodule : gmlc_top

// ### dv/gmlc_props.sv
// Purpose: port checks on gmlc_top
// Assumes: one clock, sync reset
// Notes:   bound at foot
`timescale 1ns/1ps
module gmlc_props
  import gmlc_pkg::*;
#(parameter logic [12:0] P_BIT_CYC_LO = 13'd16)
(
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_hsel,
  input wire logic [7:0]  i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_txd,
  input wire logic        o_irq
);
  // low run of the line, must be whole low-rate bit times (P_BIT_CYC_LO)
  logic [15:0] low_q;
  always_ff @(posedge i_ref_clk) low_q <= (i_rst || o_txd) ? 16'h0 : low_q + 16'h1;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence rd_s; i_hsel && i_hready && i_htrans[1] && !i_hwrite; endsequence
  sequence wr_s; i_hsel && i_hready && i_htrans[1] && i_hwrite; endsequence
  resp_okay_a: assert property (!o_hresp) else $error("hresp not okay");
  read_wait_a: assert property (rd_s |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read wait wrong");
  write_nowait_a: assert property (wr_s |=> o_hreadyout) else $error("write stalled");
  rdata_idle_a: assert property (!o_hreadyout |-> o_hrdata == 0)
    else $error("hrdata not zero");
  reset_out_a: assert property ($past(i_rst) |-> o_txd && !o_irq && o_hreadyout)
    else $error("reset outputs wrong");
  status_rsvd_a: assert property (rd_s ##0 i_haddr == GMLC_A_STATUS
    |-> ##2 o_hrdata[31:16] == 0 && o_hrdata[11:7] == 0) else $error("status reserved set");
  unmap_zero_a: assert property (rd_s ##0 i_haddr == 8'h80 |-> ##2 o_hrdata == 0)
    else $error("unmapped read nonzero");
  bit_time_a: assert property ($rose(o_txd) |-> low_q % P_BIT_CYC_LO == 0)
    else $error("bit time wrong");
endmodule : gmlc_props
bind gmlc_top gmlc_props #(.P_BIT_CYC_LO(P_BIT_CYC_LO)) u_props (.i_ref_clk(i_ref_clk),
  .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hreadyout(o_hreadyout),
  .o_hresp(o_hresp), .o_hrdata(o_hrdata), .o_txd(o_txd), .o_irq(o_irq));

// ### dv/gmlc_modem.sv
// Purpose: modem model, answers after the line goes quiet
// Assumes: 8 data bits, no parity, 1 stop
// Notes:   rxd idles high between frames
`timescale 1ns/1ps
module gmlc_modem #(parameter int P_BIT = 16)
(
  input wire logic    i_ref_clk,
  input wire logic    i_txd,
  output logic        o_rxd,
  output logic [15:0] o_got
);
  int quiet;
  logic [7:0] rb;
  task send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_rxd <= f[i];
      repeat (P_BIT) @(posedge i_ref_clk);
    end
  endtask : send
  initial o_rxd = 1'b1;
  initial o_got = 16'h0000;
  // hear the block: eight bits after start, so a 7-bit frame shows its parity in bit 7
  initial forever begin
    @(negedge i_txd);
    repeat (P_BIT / 2) @(posedge i_ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (P_BIT) @(posedge i_ref_clk);
      rb[i] = i_txd;
    end
    o_got <= {o_got[7:0], rb};
  end
  initial forever begin
    @(negedge i_txd);
    quiet = 0;
    // wait for the whole command, then reply
    while (quiet < 12 * P_BIT) begin
      @(posedge i_ref_clk);
      quiet = i_txd ? quiet + 1 : 0;
    end
    send(8'h4f);
    send(8'h4b);
  end
endmodule : gmlc_modem

// ### dv/tb_gsm_modem_link_control.sv
// Purpose: self-checking bench for gmlc_top
// Assumes: short bit and second counts
// Notes:   modem model on the serial pins
`timescale 1ns/1ps
module tb_gsm_modem_link_control;
  import gmlc_pkg::*;
  logic clk = 0, rst = 1, sel = 0, wr = 0, hr, txd, irq, rxd;
  logic [1:0]  tr = 0;
  logic [7:0]  ad = 0;
  logic [31:0] wd = 0, rd, r;
  logic [15:0] got;
  wire         rdy;
  int          bad_count = 0, n_compared = 0, cyc = 0, n;
  always #10 clk = ~clk;
  gmlc_top #(.P_BIT_CYC_LO(13'd16), .P_CYC_PER_SEC(26'd100), .P_RSP_CYC(26'd2000)) dut (
    .i_ref_clk(clk), .i_rst(rst), .i_hsel(sel), .i_haddr(ad), .i_htrans(tr),
    .i_hwrite(wr), .i_hsize(3'h2), .i_hwdata(wd), .i_hready(rdy), .o_hreadyout(rdy),
    .o_hresp(hr), .o_hrdata(rd), .o_txd(txd), .i_rxd(rxd), .o_irq(irq));
  gmlc_modem #(.P_BIT(16)) u_modem (.i_ref_clk(clk), .i_txd(txd), .o_rxd(rxd), .o_got(got));
  task results;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      results();
    end
  end
  task x(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    sel <= 1; ad <= a; wr <= w; tr <= 2'h2;
    do @(posedge clk); while (rdy !== 1'b1);
    tr <= 2'h0; wd <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    r = rd;
  endtask : x
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    x(0, a, 0);
    chk(nm, e, r);
  endtask : rc
  task t_format;
    rc("cfg", GMLC_A_CFG, 32'h1);
    rc("status", GMLC_A_STATUS, 32'h0);
    rc("unmapped", 8'h80, 32'h0);
    x(1, GMLC_A_CFG, 32'h7);
    rc("par3", GMLC_A_CFG, 32'h1);
    x(1, GMLC_A_CFG, 32'h1c);
    rc("7e2 fast", GMLC_A_CFG, 32'h1c);
    x(1, GMLC_A_CFG, 32'h3);
    rc("8o1", GMLC_A_CFG, 32'h3);
    x(1, GMLC_A_CTRL, 32'h1);
    rc("dflt", GMLC_A_CFG, 32'h1);
  endtask : t_format
  task t_pin;
    x(1, GMLC_A_IRQ_MSK, 32'h4);
    x(1, GMLC_A_PIN, 32'h12a4);
    rc("bad pin", GMLC_A_PIN, 32'h0);
    rc("pin irq", GMLC_A_IRQ_ST, 32'h4);
    chk("irq hi", 32'h1, {31'h0, irq});
    x(1, GMLC_A_IRQ_ST, 32'h4);
    rc("irq clr", GMLC_A_IRQ_ST, 32'h0);
    chk("irq lo", 32'h0, {31'h0, irq});
    x(1, GMLC_A_PIN, 32'h1234);
    rc("pin set", GMLC_A_STATUS, 32'h4);
    x(1, GMLC_A_CTRL, 32'h4);
    rc("pin cancel", GMLC_A_STATUS, 32'h0);
  endtask : t_pin
  task t_status;
    x(1, GMLC_A_REPORT, 32'hffff);
    x(1, GMLC_A_STATUS, 32'h0);
    rc("flags", GMLC_A_STATUS, 32'hf078);
    x(1, GMLC_A_REPORT, 32'h0);
    x(1, GMLC_A_CFG, 32'h21);
    x(1, GMLC_A_TXDATA, 32'h141);
    rc("sms blocked", GMLC_A_IRQ_ST, 32'h20);
    chk("txd idle", 32'h1, {31'h0, txd});
    x(1, GMLC_A_IRQ_ST, 32'h20);
    x(1, GMLC_A_CFG, 32'h1);
  endtask : t_status
  task t_store;
    x(1, GMLC_A_MSC, 32'h1234_5678);
    x(1, GMLC_A_GSC, 32'h1234_5678);
    rc("centre gw", GMLC_A_GSC, 32'h1234_5678);
    rc("centre mob", GMLC_A_MSC, 32'h1234_5678);
    x(1, GMLC_A_DST2, 32'h8000_0042);
    x(1, GMLC_A_DST0, 32'h8000_0011);
    rc("one gateway", GMLC_A_DST0, 32'h0);
    x(1, GMLC_A_DST1, 32'h0000_0022);
    rc("mobile", GMLC_A_DST1, 32'h22);
    x(1, GMLC_A_VALID, 32'hff);
    rc("validity", GMLC_A_VALID, 32'hff);
  endtask : t_store
  task t_send;
    x(1, GMLC_A_TXDATA, 32'h155);
    repeat (200) @(posedge clk);
    chk("sms byte", 32'h55, {24'h0, got[7:0]});
    x(1, GMLC_A_CFG, 32'hc);
    x(1, GMLC_A_TXDATA, 32'h43);
    repeat (200) @(posedge clk);
    chk("7e2 byte", 32'hc3, {24'h0, got[7:0]});
  endtask : t_send
  // modem answers in 8n1 while the link is 7e2, so the 'O' fails parity
  task t_conn;
    x(1, GMLC_A_IRQ_MSK, 32'h2);
    x(1, GMLC_A_CTRL, 32'h2);
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk("conn irq", 32'h1, {31'h0, irq});
    rc("conn err", GMLC_A_STATUS, 32'h1);
  endtask : t_conn
  task t_init;
    x(1, GMLC_A_DELAY, 32'hf);
    rc("clamp", GMLC_A_DELAY, 32'ha);
    x(1, GMLC_A_DELAY, 32'h1);
    x(1, GMLC_A_IRQ_MSK, 32'h1);
    x(1, GMLC_A_CMD_CHR, 32'h41);
    x(1, GMLC_A_CTRL, 32'h2);
    n = 0;
    while (txd === 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("wait", 32'h1, 32'(n >= 95 && n <= 110));
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    rc("init ok", GMLC_A_STATUS, 32'h2);
    rc("rx byte", GMLC_A_RXDATA, 32'h4b);
    chk("cmd sent", 32'h410d, {16'h0, got});
  endtask : t_init
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    t_format();
    t_pin();
    t_status();
    t_store();
    t_init();
    t_send();
    t_conn();
    results();
  end
endmodule : tb_gsm_modem_link_control
